/* File: hrc_core.sv */
/*
  Datapath of a small Harvard 8-bit core: 12-bit fetch, two-stage pipeline,
  8-bit ALU with working register, file registers reached directly or
  through the pointer register, and a two-level return stack.
  Assumes program memory answers combinationally to pmem_addr_out and that
  clk_in, ce_in and pmem_data_in all belong to the one clock domain.
*/
`include "hrc_regs.svh"

module hrc_core
  import hrc_pkg::*;
#(
  parameter int PMEM_DEPTH = `HRC_DEFAULT_PMEM_DEPTH
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic [11:0] pmem_data_in,
  output logic [`HRC_PC_W-1:0] pmem_addr_out,
  output hrc_obs_s obs_out
);

  localparam logic [`HRC_PC_W-1:0] PC_LAST = `HRC_PC_W'(PMEM_DEPTH - 1);
  localparam logic [3:0] DIV_LAST = 4'(`HRC_INSN_CLKS - 1);

  hrc_state_s st_q;
  hrc_state_s st_d;
  hrc_op_e op;
  logic tick;
  logic exec;
  logic taken;
  logic w_wr;
  logic [4:0] faddr;
  logic [7:0] fop;
  logic [7:0] opb;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] res;
  logic [7:0] bmask;
  logic dsel;
  logic we_file;
  logic we_w;
  logic upd_z;
  logic upd_c;
  logic upd_dc;
  logic c_new;
  logic skip;
  logic jump;
  logic is_sub;
  logic [`HRC_PC_W-1:0] tgt;
  logic [`HRC_PC_W-1:0] pc_inc;
  logic [1:0] page;

  // Decode the instruction held in the execute stage.
  always_comb begin
    unique casez (st_q.ir[11:6])
      6'b0000_00: op = (st_q.ir[5]) ? OP_MOVWF : OP_NOP;
      6'b0000_01: op = OP_CLR;
      6'b0000_10: op = OP_SUB;
      6'b0000_11: op = OP_DEC;
      6'b0001_00: op = OP_IOR;
      6'b0001_01: op = OP_AND;
      6'b0001_10: op = OP_XOR;
      6'b0001_11: op = OP_ADD;
      6'b0010_00: op = OP_MOV;
      6'b0010_01: op = OP_COM;
      6'b0010_10: op = OP_INC;
      6'b0010_11: op = OP_DECSZ;
      6'b0011_00: op = OP_RR;
      6'b0011_01: op = OP_RL;
      6'b0011_10: op = OP_SWAP;
      6'b0011_11: op = OP_INCSZ;
      6'b0100_??: op = OP_BCLR;
      6'b0101_??: op = OP_BSET;
      6'b0110_??: op = OP_BTSTC;
      6'b0111_??: op = OP_BTSTS;
      6'b1000_??: op = OP_RETL;
      6'b1001_??: op = OP_CALL;
      6'b101?_??: op = OP_JUMP;
      6'b1100_??: op = OP_MOVL;
      6'b1101_??: op = OP_IORL;
      6'b1110_??: op = OP_ANDL;
      6'b1111_??: op = OP_XORL;
      default: op = OP_ILL;
    endcase
  end

  // Operand fetch; address zero goes through the pointer register.
  always_comb begin
    faddr = (st_q.ir[4:0] == `HRC_ADDR_INDF) ? st_q.ram[`HRC_ADDR_FSR][4:0] : st_q.ir[4:0];
    case (faddr)
      `HRC_ADDR_INDF: fop = 8'h00; // Indirect through itself reads zero.
      `HRC_ADDR_PCL: fop = st_q.pc[7:0];
      default: fop = st_q.ram[faddr];
    endcase
  end

  // One adder serves both add and subtract; subtract adds the inverse plus one.
  always_comb begin
    is_sub = (op == OP_SUB);
    opb = is_sub ? ~st_q.w : st_q.w;
    sum = {1'b0, fop} + {1'b0, opb} + {8'h00, is_sub};
    nib = {1'b0, fop[3:0]} + {1'b0, opb[3:0]} + {4'h0, is_sub};
    bmask = 8'h01 << st_q.ir[7:5];
    page = st_q.ram[`HRC_ADDR_STATUS][`HRC_ST_PA_HI:`HRC_ST_PA_LO];
    pc_inc = (st_q.pc == PC_LAST) ? `HRC_PC_W'(0) : st_q.pc + `HRC_PC_W'(1);
  end

  // Execute: result, destinations, flags and flow changes.
  always_comb begin
    res = fop;
    dsel = 1'b0;
    we_file = 1'b0;
    we_w = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    c_new = sum[8];
    skip = 1'b0;
    jump = 1'b0;
    tgt = pc_inc;
    case (op)
      OP_MOVWF: begin
        res = st_q.w;
        we_file = 1'b1;
      end
      OP_CLR: begin
        res = 8'h00;
        dsel = 1'b1;
        upd_z = 1'b1;
      end
      OP_SUB, OP_ADD: begin
        res = sum[7:0];
        dsel = 1'b1;
        upd_z = 1'b1;
        upd_c = 1'b1;
        upd_dc = 1'b1;
      end
      OP_DEC, OP_DECSZ: begin
        res = fop - 8'h01;
        dsel = 1'b1;
        upd_z = (op == OP_DEC);
        skip = (op == OP_DECSZ) && (res == 8'h00);
      end
      OP_INC, OP_INCSZ: begin
        res = fop + 8'h01;
        dsel = 1'b1;
        upd_z = (op == OP_INC);
        skip = (op == OP_INCSZ) && (res == 8'h00);
      end
      OP_IOR, OP_AND, OP_XOR: begin
        res = (op == OP_IOR) ? (fop | st_q.w) : (op == OP_AND) ? (fop & st_q.w) : (fop ^ st_q.w);
        dsel = 1'b1;
        upd_z = 1'b1;
      end
      OP_MOV, OP_COM, OP_SWAP: begin
        res = (op == OP_MOV) ? fop : (op == OP_COM) ? ~fop : {fop[3:0], fop[7:4]};
        dsel = 1'b1;
        upd_z = (op != OP_SWAP);
      end
      OP_RR, OP_RL: begin
        // Rotates run through the carry, so they are nine-bit shifts.
        res = (op == OP_RR) ? {st_q.ram[`HRC_ADDR_STATUS][`HRC_ST_C], fop[7:1]}
                            : {fop[6:0], st_q.ram[`HRC_ADDR_STATUS][`HRC_ST_C]};
        c_new = (op == OP_RR) ? fop[0] : fop[7];
        dsel = 1'b1;
        upd_c = 1'b1;
      end
      OP_BCLR, OP_BSET: begin
        res = (op == OP_BSET) ? (fop | bmask) : (fop & ~bmask);
        we_file = 1'b1;
      end
      OP_BTSTC: skip = ((fop & bmask) == 8'h00);
      OP_BTSTS: skip = ((fop & bmask) != 8'h00);
      OP_RETL: begin
        res = st_q.ir[7:0];
        we_w = 1'b1;
        jump = 1'b1;
        tgt = st_q.stack0;
      end
      OP_CALL: begin
        jump = 1'b1;
        tgt = `HRC_PC_W'({page, 1'b0, st_q.ir[7:0]});
      end
      OP_JUMP: begin
        jump = 1'b1;
        tgt = `HRC_PC_W'({page, st_q.ir[8:0]});
      end
      OP_MOVL, OP_IORL, OP_ANDL, OP_XORL: begin
        res = (op == OP_MOVL) ? st_q.ir[7:0] : (op == OP_IORL) ? (st_q.ir[7:0] | st_q.w) :
              (op == OP_ANDL) ? (st_q.ir[7:0] & st_q.w) : (st_q.ir[7:0] ^ st_q.w);
        we_w = 1'b1;
        upd_z = (op != OP_MOVL);
      end
      default: ;
    endcase
    if (dsel) begin
      we_file = st_q.ir[5];
      we_w = !st_q.ir[5];
    end
    // Writing the low counter byte is a computed jump within the page.
    if (we_file && faddr == `HRC_ADDR_PCL) begin
      jump = 1'b1;
      tgt = `HRC_PC_W'({page, 1'b0, res});
    end
  end

  // Sequencing: one instruction cycle every HRC_INSN_CLKS clock enables.
  always_comb begin
    tick = ce_in && (st_q.div == DIV_LAST);
    exec = tick && st_q.ir_valid;
    taken = exec && (jump || skip);
    w_wr = exec && we_w;
    st_d = st_q;
    if (tick) begin
      st_d.div = 4'h0;
      st_d.ir = pmem_data_in;
      st_d.ir_valid = !taken;
      st_d.pc = pc_inc;
      if (taken && jump) begin
        st_d.pc = (tgt > PC_LAST) ? `HRC_PC_W'(0) : tgt;
      end
      if (exec && op == OP_CALL) begin
        st_d.stack1 = st_q.stack0;
        st_d.stack0 = st_q.pc;
      end
      if (exec && op == OP_RETL) begin
        st_d.stack0 = st_q.stack1;
      end
      if (w_wr) begin
        st_d.w = res;
      end
      if (exec && we_file && faddr != `HRC_ADDR_INDF && faddr != `HRC_ADDR_PCL) begin
        st_d.ram[faddr] = res;
        // Power-down and time-out bits are not writable by software.
        if (faddr == `HRC_ADDR_STATUS) begin
          st_d.ram[faddr][4:3] = st_q.ram[faddr][4:3];
        end
      end
      // Flag updates come after the file write, so they win on a status target.
      if (exec && upd_z) begin
        st_d.ram[`HRC_ADDR_STATUS][`HRC_ST_Z] = (res == 8'h00);
      end
      if (exec && upd_c) begin
        st_d.ram[`HRC_ADDR_STATUS][`HRC_ST_C] = c_new;
      end
      if (exec && upd_dc) begin
        st_d.ram[`HRC_ADDR_STATUS][`HRC_ST_DC] = nib[4];
      end
    end else if (ce_in) begin
      st_d.div = st_q.div + 4'h1;
    end
  end

  // Single state register; reset empties the execute stage like a branch, and the first fetch is kept.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
      st_q.pc <= `HRC_PC_RST;
      st_q.ram[`HRC_ADDR_STATUS] <= `HRC_STATUS_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign pmem_addr_out = st_q.pc;
  assign obs_out = '{pc: st_q.pc, w: st_q.w, status: st_q.ram[`HRC_ADDR_STATUS],
                     exec_valid: st_q.ir_valid};

  a_tick_spacing: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tick |=> !tick [*8]) else $error("Instruction cycles closer than the cycle time.");
  a_ir_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tick |=> st_q.ir == $past(pmem_data_in)) else $error("Fetched word not latched.");
  a_pc_on_tick: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $changed(st_q.pc) |-> $past(tick)) else $error("Counter moved outside a cycle.");
  a_branch_flush: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tick && taken |=> !st_q.ir_valid) else $error("Prefetch kept after flow change.");
  a_bubble_once: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    tick && !st_q.ir_valid |=> st_q.ir_valid) else $error("Bubble longer than one cycle.");
  a_pc_range: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_q.pc <= PC_LAST) else $error("Counter beyond program memory.");
  a_w_private: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $changed(st_q.w) |-> $past(w_wr)) else $error("Accumulator written without cause.");
  a_zero_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec && upd_z |=> st_q.ram[`HRC_ADDR_STATUS][`HRC_ST_Z] == ($past(res) == 8'h00))
    else $error("Zero flag wrong.");
  a_add_carry: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec && op == OP_ADD |=> st_q.ram[`HRC_ADDR_STATUS][`HRC_ST_C] ==
      (({1'b0, $past(fop)} + {1'b0, $past(st_q.w)}) > 9'h0ff))
    else $error("Add carry wrong.");
  a_sub_borrow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec && op == OP_SUB |=> st_q.ram[`HRC_ADDR_STATUS][`HRC_ST_C] == ($past(fop) >= $past(st_q.w)))
    else $error("Subtract borrow wrong.");
  a_indirect_wr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    exec && we_file && st_q.ir[4:0] == 5'h00 && faddr > `HRC_ADDR_FSR
    |=> st_q.ram[$past(faddr)] == $past(res)) else $error("Indirect write lost.");

endmodule : hrc_core

/* File: hrc_regs.svh */
/*
  Constants of the small Harvard core datapath: file register addresses,
  status bit positions, reset values and instruction cycle timing.
  Assumes it is included by its bare name wherever the core is compiled.
*/
`ifndef HRC_REGS_SVH
`define HRC_REGS_SVH

// Special file register addresses inside the data memory space.
`define HRC_ADDR_INDF 5'h00
`define HRC_ADDR_PCL 5'h02
`define HRC_ADDR_STATUS 5'h03
`define HRC_ADDR_FSR 5'h04

// Status register bit positions.
`define HRC_ST_C 0
`define HRC_ST_DC 1
`define HRC_ST_Z 2
`define HRC_ST_PA_LO 5
`define HRC_ST_PA_HI 6

// Reset values.
`define HRC_STATUS_RST 8'h18
`define HRC_PC_RST 11'h000

// Instruction cycle timing: the cycle time in ns and the clock period in ns.
`define HRC_INSN_CYCLE_NS 200
`define HRC_CLK_PERIOD_NS 20
`define HRC_INSN_CLKS ((`HRC_INSN_CYCLE_NS + `HRC_CLK_PERIOD_NS - 1) / `HRC_CLK_PERIOD_NS)

// Sizes of the fixed storage.
`define HRC_FILE_DEPTH 32
`define HRC_PC_W 11
`define HRC_DEFAULT_PMEM_DEPTH 2048

`endif

/* File: hrc_pkg.sv */
/*
  Types of the small Harvard core datapath: operation enum, the single
  packed state record and the observation bundle driven out of the core.
  Assumes hrc_regs.svh supplies the sizes.
*/
`include "hrc_regs.svh"

package hrc_pkg;

  // Decoded operation of the instruction in the execute stage.
  typedef enum logic [4:0] {
    OP_NOP, OP_MOVWF, OP_CLR, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR,
    OP_ADD, OP_MOV, OP_COM, OP_INC, OP_DECSZ, OP_RR, OP_RL, OP_SWAP,
    OP_INCSZ, OP_BCLR, OP_BSET, OP_BTSTC, OP_BTSTS, OP_RETL, OP_CALL,
    OP_JUMP, OP_MOVL, OP_IORL, OP_ANDL, OP_XORL, OP_ILL
  } hrc_op_e;

  // Whole state of the core; the file array holds the status and pointer too.
  typedef struct packed {
    logic [3:0] div;
    logic [`HRC_PC_W-1:0] pc;
    logic [11:0] ir;
    logic ir_valid;
    logic [7:0] w;
    logic [`HRC_PC_W-1:0] stack0;
    logic [`HRC_PC_W-1:0] stack1;
    logic [`HRC_FILE_DEPTH-1:0][7:0] ram;
  } hrc_state_s;

  // Visible state for the rest of the chip.
  typedef struct packed {
    logic [`HRC_PC_W-1:0] pc;
    logic [7:0] w;
    logic [7:0] status;
    logic exec_valid;
  } hrc_obs_s;

endpackage : hrc_pkg

/* File: hrc_pmem_model.sv */
/*
  Program memory model standing on the far side of the core's fetch port.
  Assumes the bench fills mem before reset is released and that the core
  reads it combinationally, one address per instruction cycle.
*/
module hrc_pmem_model
  import hrc_pkg::*;
#(
  parameter int DEPTH = 384
) (
  input wire logic [10:0] addr_in,
  output logic [11:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [11:0] mem [DEPTH];

  // A whole word is answered at once; an address past the depth yields an
  // all-ones word, so a counter that fails to wrap shows up as an XOR of the accumulator with ff.
  assign data_out = (addr_in < 11'(DEPTH)) ? mem[addr_in] : 12'hfff;
endmodule : hrc_pmem_model

/* File: test_harvard_risc_core_datapath.sv */
/*
  Self-checking bench of the core datapath: a random program with skips and
  bit operations, a jump over one word, a call and return, a computed jump,
  wrap of the counter at the top of memory, random clock-enable gaps and a
  reset in mid-run, all against an integer model.
  Assumes hrc_pkg, hrc_core and hrc_pmem_model are compiled before it.
*/
module test_harvard_risc_core_datapath
  import hrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int DEPTH = 384;
  logic clk_in;
  logic sys_rst_in;
  logic ce_in;
  logic [11:0] pmem_data;
  logic [10:0] pmem_addr;
  hrc_obs_s obs;
  int n_errors = 0;
  int samples_checked = 0;
  int prog [DEPTH];
  int m_pc, m_w, m_st, m_ir, m_v, m_div;
  int m_s0, m_s1, m_pj;
  int m_ram [32];
  bit run = 0;

  hrc_core #(.PMEM_DEPTH(DEPTH)) uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .ce_in(ce_in), .pmem_data_in(pmem_data), .pmem_addr_out(pmem_addr), .obs_out(obs));
  hrc_pmem_model #(.DEPTH(DEPTH)) pm (.addr_in(pmem_addr), .data_out(pmem_data));

  // Free-running 50 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic chk_addr(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_addr

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_addr({3'h0, got}, {3'h0, exp});
  endtask : chk_byte

  // File 0 reaches through the pointer in file 4; pointing at 0 reads zero.
  function automatic int fa(int f);
    return (f == 0) ? (m_ram[4] & 31) : f;
  endfunction : fa

  // A flow change past the top of program memory lands on word zero.
  function automatic int pc_tgt(int a);
    return (a < DEPTH) ? a : 0;
  endfunction : pc_tgt

  // File 2 reads the low counter byte and file 3 the status byte.
  function automatic int rd(int f);
    case (fa(f))
      0: return 0;
      2: return m_pc & 255;
      3: return m_st;
      default: return m_ram[fa(f)];
    endcase
  endfunction : rd

  // A write to file 2 is remembered as a computed jump, not stored.
  task automatic wr(input int f, input int v);
    if (fa(f) == 2) m_pj = 256 | v;
    else if (fa(f) != 0) m_ram[fa(f)] = v;
  endtask : wr

  task automatic setf(input int b, input bit v);
    m_st = v ? (m_st | (1 << b)) : (m_st & ~(1 << b));
  endtask : setf

  // Reference execution of one word; the accumulator lives outside m_ram.
  task automatic exec_insn(input int i, output bit fl);
    int f, a, r, c, t, b, pg;
    bit wb, sk;
    f = i & 31;
    a = rd(f);
    c = m_st & 1;
    t = i >> 6;
    b = (i >> 5) & 7;
    pg = ((m_st >> 5) & 3) << 9;
    wb = 1;
    fl = 0;
    sk = 0;
    m_pj = 0;
    r = 0;
    case (i >> 8)
      12: m_w = i & 255;
      13: m_w |= i & 255;
      14: m_w &= i & 255;
      15: m_w ^= i & 255;
      10, 11: begin
        m_pc = pc_tgt(pg | (i & 511));
        fl = 1;
      end
      9: begin
        m_s1 = m_s0;
        m_s0 = m_pc;
        m_pc = pc_tgt(pg | (i & 255));
        fl = 1;
      end
      8: begin
        m_w = i & 255;
        m_pc = m_s0;
        m_s0 = m_s1;
        fl = 1;
      end
      4, 5: wr(f, ((i >> 8) == 5) ? (a | (1 << b)) : (a & ~(1 << b)));
      6, 7: sk = ((i >> 8) == 7) == (((a >> b) & 1) == 1);
      default: ;
    endcase
    if (i >= 12'hd00) setf(2, m_w == 0);
    if ((i >> 8) > 3) wb = 0;
    else if ((i >> 5) == 1) begin
      wr(f, m_w);
      wb = 0;
    end else case (t)
      1: r = 0;
      2: begin
        r = a - m_w;
        setf(0, a >= m_w);
        setf(1, (a & 15) >= (m_w & 15));
      end
      3: r = a - 1;
      4: r = a | m_w;
      5: r = a & m_w;
      6: r = a ^ m_w;
      7: begin
        r = a + m_w;
        setf(0, r > 255);
        setf(1, (a & 15) + (m_w & 15) > 15);
      end
      8: r = a;
      9: r = ~a;
      10: r = a + 1;
      12: begin
        r = (a >> 1) | (c << 7);
        setf(0, a & 1);
      end
      13: begin
        r = (a << 1) | c;
        setf(0, (a >> 7) & 1);
      end
      14: r = ((a & 15) << 4) | (a >> 4);
      11: r = a - 1;
      15: r = a + 1;
      default: wb = 0;
    endcase
    if (wb) begin
      r &= 255;
      if ((i >> 5) & 1) wr(f, r);
      else m_w = r;
      if (t <= 10) setf(2, r == 0);
      if (t == 11 || t == 15) sk = (r == 0);
    end
    // A skip steps over the prefetched word; both cost a discarded fetch.
    if (sk) m_pc = (m_pc + 1) % DEPTH;
    if (m_pj != 0) m_pc = pc_tgt(pg | (m_pj & 255));
    fl = fl | sk | (m_pj != 0);
  endtask : exec_insn

  // Cycle model: one instruction tick every ten enabled clocks.
  always @(posedge clk_in) begin : model
    bit fl;
    if (sys_rst_in) begin
      m_pc = 0;
      m_w = 0;
      m_st = 8'h18;
      m_v = 0;
      m_ir = 0;
      m_div = 0;
      m_s0 = 0;
      m_s1 = 0;
      foreach (m_ram[k]) m_ram[k] = 0;
    end else if (ce_in) begin
      if (m_div == 9) begin
        m_div = 0;
        fl = 0;
        if (m_v != 0) exec_insn(m_ir, fl);
        m_v = !fl;
        if (!fl) begin
          m_ir = prog[m_pc];
          m_pc = (m_pc + 1) % DEPTH;
        end
      end else m_div++;
    end
  end

  // Outputs settle long before the falling edge, so compare there.
  always @(negedge clk_in) begin
    if (run) begin
      chk_addr(pmem_addr, m_pc[10:0]);
      chk_addr(obs.pc, m_pc[10:0]);
      chk_byte({7'h00, obs.exec_valid}, m_v[7:0]);
      chk_byte(obs.w, m_w[7:0]);
      chk_byte(obs.status, m_st[7:0]);
    end
  end

  // Stimulus: a random program, then enable gaps and a reset in mid-run.
  initial begin
    int f, op, t;
    sys_rst_in = 1'b1;
    ce_in = 1'b1;
    void'($urandom(40));
    for (int k = 0; k < DEPTH; k++) begin
      f = $urandom % 25;
      f = (f == 24) ? 0 : f + 8;
      op = $urandom % 20;
      t = (op > 14) ? op - 3 : op - 4;
      if (k > 59) begin
        // Jump over a word, call and return, read counter and status, then a
        // computed jump; the jump at 249 keeps the return from being replayed.
        case (k)
          60: prog[k] = 12'ha3e;
          61, 67: prog[k] = 12'hc5a;
          62: prog[k] = 12'h9fa;
          63: prog[k] = 12'h202;
          64: prog[k] = 12'h203;
          65: prog[k] = 12'hc44;
          66: prog[k] = 12'h022;
          249: prog[k] = 12'hafb;
          250: prog[k] = 12'h833;
          default: prog[k] = 0;
        endcase
      end else if (k % 16 == 14) prog[k] = 12'hc00 | (8 + $urandom % 24);
      else if (k % 16 == 15) prog[k] = 12'h024;
      else if (op < 4) prog[k] = ((12 + op) << 8) | ($urandom % 256);
      else if (op == 4) prog[k] = 12'h020 | f;
      else if (op == 18) prog[k] = ((4 + $urandom % 4) << 8) | (($urandom % 8) << 5) | f;
      else if (op == 19) prog[k] = ((11 + 4 * ($urandom % 2)) << 6) | (($urandom % 2) << 5) | f;
      else prog[k] = (t << 6) | (($urandom % 2) << 5) | f;
      pm.mem[k] = prog[k][11:0];
    end
    repeat (4) @(negedge clk_in);
    sys_rst_in = 1'b0;
    run = 1'b1;
    repeat (6500) begin
      @(negedge clk_in);
      ce_in = ($urandom % 4) != 0;
    end
    sys_rst_in = 1'b1;
    repeat (4) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (1500) begin
      @(negedge clk_in);
      ce_in = ($urandom % 4) != 0;
    end
    summarize();
  end

  // Watchdog: about two and a half times the expected run length.
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule : test_harvard_risc_core_datapath
